// [src/rssalu_cfg.svh]
`ifndef RSSALU_CFG_SVH
`define RSSALU_CFG_SVH
// ==========================================================
// Constants
// Data and address widths
`define RSSALU_DATA_W 8
`define RSSALU_ADDR_W 7
// Destination select encodings
`define RSSALU_DEST_ACC 1'h0
`define RSSALU_DEST_REG 1'h1
// Reset values
`define RSSALU_ACC_RST 8'h00
`define RSSALU_WDT_RST 8'h00
`define RSSALU_PRE_RST 8'h00
`define RSSALU_HALF_LSB 3
// Status flag values at reset
`define RSSALU_PD_RST 1'h1
`define RSSALU_TO_RST 1'h1
// Last prescaler count before the watchdog counter steps
`define RSSALU_PRE_MAX 8'hFF
`endif

// [src/rssalu_core.sv]
`timescale 1ns/1ps
`include "rssalu_cfg.svh"
module rssalu_core (
  input wire logic sys_clk_in, // Core instruction clock
  input wire logic rstn_in, // Asynchronous reset, active low
  input wire logic ce_in, // Clock enable, freezes state when low
  input wire logic op_valid_in, // Instruction present this cycle
  input wire logic [2:0] op_code_in, // Operation code
  input wire logic [6:0] file_addr_in, // File register address
  input wire logic dest_in, // Destination select bit
  input wire logic [7:0] literal_in, // Immediate literal
  input wire logic [7:0] file_rd_data_in, // Addressed register value
  input wire logic wake_in, // Wake event ends sleep
  input wire logic wdt_tick_in, // Watchdog prescaler clock tick
  output logic [6:0] file_rd_addr_out, // Register file read address
  output logic file_wr_en_out, // Register file write strobe
  output logic [6:0] file_wr_addr_out, // Register file write address
  output logic [7:0] file_wr_data_out, // Register file write data
  output logic [7:0] acc_out, // Accumulator
  output logic carry_out, // Carry flag
  output logic half_carry_out, // Half carry flag
  output logic zero_out, // Zero flag
  output logic powerdown_flag_out, // Power-down status, low after sleep
  output logic watchdog_expiry_flag_out, // Expiry status, high after sleep
  output logic [7:0] watchdog_counter_out, // Watchdog count
  output logic halted_out, // Execution halted
  output logic osc_stop_out // Main oscillator stop request
);

  // ==========================================================
  // State
  rssalu_pkg::rssalu_state_t_type s_q; // Registered state
  rssalu_pkg::rssalu_state_t_type s_d; // Next state
  rssalu_pkg::rssalu_op_type op; // Decoded operation
  logic [8:0] diff; // Nine-bit difference, top bit is borrow-free
  logic [4:0] hdiff; // Low-nibble difference
  logic [7:0] minuend; // Literal or register operand
  logic [7:0] result; // Operation result
  logic take; // Instruction accepted

  assign op = rssalu_pkg::rssalu_op_type'(op_code_in);
  assign take = op_valid_in && (s_q.st == rssalu_pkg::ST_RUN);
  // Address goes straight through; its 7-bit width bounds it to 0..127
  assign file_rd_addr_out = file_addr_in;

  // ==========================================================
  // Arithmetic
  // Minuend is the literal or the addressed register
  always_comb begin
    minuend = (op == rssalu_pkg::OP_LIT_SUB) ? literal_in : file_rd_data_in;
    // Adding ninth bit makes the top bit read as "no borrow" directly
    diff = {1'h1, minuend} - {1'h0, s_q.acc};
    hdiff = {1'h1, minuend[3:0]} - {1'h0, s_q.acc[3:0]};
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.wr_en = 1'h0;
    result = 8'h00;
    if (wdt_tick_in) begin
      // Watchdog keeps counting, also while asleep
      s_d.prescaler = s_q.prescaler + 8'h01;
      if (s_q.prescaler == `RSSALU_PRE_MAX) begin
        s_d.watchdog_counter = s_q.watchdog_counter + 8'h01;
      end
    end
    if (s_q.st == rssalu_pkg::ST_ASLEEP) begin
      // Only a wake event or a reset resumes execution
      if (wake_in) begin
        s_d.st = rssalu_pkg::ST_RUN;
      end
    end else if (take) begin
      case (op)
        rssalu_pkg::OP_ROT_RIGHT: begin
          result = {s_q.carry, file_rd_data_in[7:1]};
          s_d.carry = file_rd_data_in[0];
        end
        rssalu_pkg::OP_ROT_LEFT: begin
          result = {file_rd_data_in[6:0], s_q.carry};
          s_d.carry = file_rd_data_in[7];
        end
        rssalu_pkg::OP_LIT_SUB, rssalu_pkg::OP_REG_SUB: begin
          result = diff[7:0];
          s_d.carry = diff[8];
          s_d.half_carry = hdiff[4];
          s_d.zero = (diff[7:0] == 8'h00);
        end
        rssalu_pkg::OP_SLEEP: begin
          s_d.powerdown_flag = 1'h0;
          s_d.watchdog_expiry_flag = 1'h1;
          s_d.watchdog_counter = `RSSALU_WDT_RST;
          s_d.prescaler = `RSSALU_PRE_RST;
          s_d.st = rssalu_pkg::ST_ASLEEP;
        end
        default: begin
          result = 8'h00;
        end
      endcase
      // Route result by destination; literal form always to accumulator
      if (op == rssalu_pkg::OP_LIT_SUB) begin
        s_d.acc = result;
      end else if (op == rssalu_pkg::OP_ROT_RIGHT ||
                   op == rssalu_pkg::OP_ROT_LEFT ||
                   op == rssalu_pkg::OP_REG_SUB) begin
        if (dest_in == `RSSALU_DEST_ACC) begin
          s_d.acc = result;
        end else begin
          s_d.wr_en = 1'h1;
          s_d.wr_addr = file_addr_in;
          s_d.wr_data = result;
        end
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
      s_q.powerdown_flag <= `RSSALU_PD_RST;
      s_q.watchdog_expiry_flag <= `RSSALU_TO_RST;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign file_wr_en_out = s_q.wr_en;
  assign file_wr_addr_out = s_q.wr_addr;
  assign file_wr_data_out = s_q.wr_data;
  assign acc_out = s_q.acc;
  assign carry_out = s_q.carry;
  assign half_carry_out = s_q.half_carry;
  assign zero_out = s_q.zero;
  assign powerdown_flag_out = s_q.powerdown_flag;
  assign watchdog_expiry_flag_out = s_q.watchdog_expiry_flag;
  assign watchdog_counter_out = s_q.watchdog_counter;
  // Oscillator stop follows the sleep state
  assign halted_out = (s_q.st == rssalu_pkg::ST_ASLEEP);
  assign osc_stop_out = (s_q.st == rssalu_pkg::ST_ASLEEP);

  // ==========================================================
  // Operands are read back through $past, so the checks keep no state
  // of their own that the clock enable would have to freeze as well

  property p_rotr;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && take && op == rssalu_pkg::OP_ROT_RIGHT) |=>
      carry_out == $past(file_rd_data_in[0]) &&
      ($past(dest_in) ? file_wr_data_out : acc_out) ==
        {$past(carry_out), $past(file_rd_data_in[7:1])};
  endproperty
  a_rotr: assert property (p_rotr) else $error("Rotate right carry");

  property p_rotl;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && take && op == rssalu_pkg::OP_ROT_LEFT) |=>
      carry_out == $past(file_rd_data_in[7]) &&
      ($past(dest_in) ? file_wr_data_out : acc_out) ==
        {$past(file_rd_data_in[6:0]), $past(carry_out)};
  endproperty
  a_rotl: assert property (p_rotl) else $error("Rotate left carry");

  property p_dest_reg;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && take && op == rssalu_pkg::OP_REG_SUB && dest_in) |=>
      file_wr_en_out && $stable(acc_out);
  endproperty
  a_dest_reg: assert property (p_dest_reg) else $error("Dest reg");

  property p_dest_acc;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && take && op == rssalu_pkg::OP_ROT_RIGHT && !dest_in) |=>
      !file_wr_en_out;
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("Dest acc");

  // A write-back must land at the address that came with the instruction
  property p_addr;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && take && dest_in &&
     (op == rssalu_pkg::OP_ROT_RIGHT || op == rssalu_pkg::OP_ROT_LEFT ||
      op == rssalu_pkg::OP_REG_SUB)) |=>
      file_wr_en_out && file_wr_addr_out == $past(file_addr_in);
  endproperty
  a_addr: assert property (p_addr) else $error("Address path");

  property p_lit;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && take && op == rssalu_pkg::OP_LIT_SUB) |=>
      acc_out == 8'($past(literal_in) - $past(acc_out)) &&
      !file_wr_en_out;
  endproperty
  a_lit: assert property (p_lit) else $error("Literal subtract");

  property p_flags;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && take && op == rssalu_pkg::OP_LIT_SUB) |=>
      carry_out == ($past(acc_out) <= $past(literal_in)) &&
      half_carry_out ==
        ($past(acc_out[3:0]) <= $past(literal_in[3:0])) &&
      zero_out == (acc_out == 8'h00);
  endproperty
  a_flags: assert property (p_flags) else $error("Subtract flags");

  property p_regsub;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && take && op == rssalu_pkg::OP_REG_SUB && dest_in) |=>
      file_wr_data_out ==
        8'($past(file_rd_data_in) - $past(acc_out)) &&
      carry_out == ($past(acc_out) <= $past(file_rd_data_in));
  endproperty
  a_regsub: assert property (p_regsub) else $error("Reg subtract");

  property p_sleep;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && take && op == rssalu_pkg::OP_SLEEP) |=>
      !powerdown_flag_out && watchdog_expiry_flag_out &&
      watchdog_counter_out == 8'h00 && halted_out && osc_stop_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("Sleep");

  // Asleep without a wake event: nothing executes, nothing is written
  property p_halt;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && halted_out && !wake_in) |=>
      halted_out && osc_stop_out && $stable(acc_out) && !file_wr_en_out;
  endproperty
  a_halt: assert property (p_halt) else $error("Halted");

  c_sleep: cover property (@(posedge sys_clk_in)
    take && op == rssalu_pkg::OP_SLEEP);
  c_borrow: cover property (@(posedge sys_clk_in)
    take && op == rssalu_pkg::OP_LIT_SUB ##1 !carry_out);
  c_wrreg: cover property (@(posedge sys_clk_in) file_wr_en_out);
  c_wake: cover property (@(posedge sys_clk_in)
    halted_out ##1 !halted_out);
endmodule // rssalu_core

// [src/rssalu_pkg.sv]
package rssalu_pkg;
  // Operation codes presented by the decoder
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ROT_RIGHT = 3'h1,
    OP_ROT_LEFT = 3'h2,
    OP_LIT_SUB = 3'h3,
    OP_REG_SUB = 3'h4,
    OP_SLEEP = 3'h5
  } rssalu_op_type;
  // Run state of the core
  typedef enum logic [0:0] {
    ST_RUN = 1'h0,
    ST_ASLEEP = 1'h1
  } rssalu_state_type;
  // All registered state of the datapath
  typedef struct packed {
    rssalu_state_type st;
    logic [7:0] acc;
    logic carry;
    logic half_carry;
    logic zero;
    logic powerdown_flag;
    logic watchdog_expiry_flag;
    logic [7:0] watchdog_counter;
    logic [7:0] prescaler;
    logic wr_en;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
  } rssalu_state_t_type;
endpackage

// [tb/rotate_subtract_sleep_alu_tb.sv]
`timescale 1ns/1ps
module rotate_subtract_sleep_alu_tb;
  // ==========================================================
  // Stimulus and observed signals
  logic sys_clk_in, rstn_in, ce_in, op_valid_in, dest_in;
  logic wake_in, wdt_tick_in, file_wr_en_out, carry_out, half_carry_out;
  logic zero_out, powerdown_flag_out, watchdog_expiry_flag_out;
  logic halted_out, osc_stop_out;
  logic [2:0] op_code_in;
  logic [6:0] file_addr_in, file_rd_addr_out, file_wr_addr_out;
  logic [7:0] literal_in, file_rd_data_in, file_wr_data_out, acc_out;
  logic [7:0] watchdog_counter_out;
  int n_fail = 0; // Mismatches
  int tests_run = 0; // Comparisons
  rssalu_core uut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .ce_in(ce_in), .op_valid_in(op_valid_in), .op_code_in(op_code_in),
    .file_addr_in(file_addr_in), .dest_in(dest_in),
    .literal_in(literal_in), .file_rd_data_in(file_rd_data_in),
    .wake_in(wake_in), .wdt_tick_in(wdt_tick_in),
    .file_rd_addr_out(file_rd_addr_out), .file_wr_en_out(file_wr_en_out),
    .file_wr_addr_out(file_wr_addr_out),
    .file_wr_data_out(file_wr_data_out), .acc_out(acc_out),
    .carry_out(carry_out), .half_carry_out(half_carry_out),
    .zero_out(zero_out), .powerdown_flag_out(powerdown_flag_out),
    .watchdog_expiry_flag_out(watchdog_expiry_flag_out),
    .watchdog_counter_out(watchdog_counter_out),
    .halted_out(halted_out), .osc_stop_out(osc_stop_out));
  // ==========================================================
  // Helpers
  // 200 MHz clock
  initial begin
    sys_clk_in = 1'h0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  // Compare and count; unknowns never match
  task automatic chk(input string what, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One instruction, entered at a falling edge; valid stays up so that
  // back-to-back calls never lower and raise it in one time step
  task automatic issue(input logic [2:0] op, input logic [6:0] a,
    input logic d, input logic [7:0] k, f);
    op_valid_in = 1'h1;
    op_code_in = op;
    file_addr_in = a;
    dest_in = d;
    literal_in = k;
    file_rd_data_in = f;
    #1 chk("rd_addr", file_rd_addr_out, a);
    @(negedge sys_clk_in);
  endtask
  // Drop valid and let one edge pass, else the last op runs again
  task automatic idle();
    op_valid_in = 1'h0;
    @(negedge sys_clk_in);
  endtask
  // Watchdog prescaler ticks, one pulse each two cycles
  task automatic tick(input int n);
    repeat (n) begin
      wdt_tick_in = 1'h1;
      @(negedge sys_clk_in);
      wdt_tick_in = 1'h0;
      @(negedge sys_clk_in);
    end
  endtask
  // ==========================================================
  // Scenarios
  // Rotates in both directions, both destinations, top address
  task automatic test_rotate();
    // Acc is zero after reset: 00 minus 00 sets carry
    issue(rssalu_pkg::OP_LIT_SUB, 7'h00, 1'h0, 8'h00, 8'h00);
    chk("carry", carry_out, 1'h1);
    issue(rssalu_pkg::OP_ROT_RIGHT, 7'h7F, 1'h0, 8'h00, 8'hA7);
    chk("acc", acc_out, 8'hD3);
    chk("carry", carry_out, 1'h1);
    chk("wr_en", file_wr_en_out, 1'h0);
    issue(rssalu_pkg::OP_ROT_RIGHT, 7'h7F, 1'h1, 8'h00, 8'h02);
    chk("wr_data", file_wr_data_out, 8'h81);
    chk("wr_addr", file_wr_addr_out, 7'h7F);
    chk("wr_en", file_wr_en_out, 1'h1);
    chk("acc", acc_out, 8'hD3);
    chk("carry", carry_out, 1'h0);
    issue(rssalu_pkg::OP_ROT_LEFT, 7'h05, 1'h1, 8'h00, 8'hC0);
    chk("wr_data", file_wr_data_out, 8'h80);
    chk("wr_addr", file_wr_addr_out, 7'h05);
    chk("carry", carry_out, 1'h1);
    issue(rssalu_pkg::OP_ROT_LEFT, 7'h00, 1'h0, 8'h00, 8'h66);
    chk("acc", acc_out, 8'hCD);
    chk("carry", carry_out, 1'h0);
    chk("wr_en", file_wr_en_out, 1'h0);
    idle();
    $display("test_rotate done");
  endtask
  // Load acc with w by two rotates, then m minus acc;
  // kind 0 literal, 1 register to acc, 2 register back to file
  task automatic test_sub(input logic [1:0] kind, input logic [7:0] w, m);
    logic [7:0] diff;
    diff = m - w;
    // Carry takes w[0], then the left rotate puts it under w[7:1]
    issue(rssalu_pkg::OP_ROT_RIGHT, 7'h10, 1'h1, 8'h00, {7'h00, w[0]});
    issue(rssalu_pkg::OP_ROT_LEFT, 7'h10, 1'h0, 8'h00, {1'h0, w[7:1]});
    chk("acc_load", acc_out, w);
    if (kind == 2'h0) begin
      issue(rssalu_pkg::OP_LIT_SUB, 7'h00, 1'h0, m, 8'h00);
    end else begin
      issue(rssalu_pkg::OP_REG_SUB, 7'h55, kind[1], 8'h00, m);
    end
    chk("acc", acc_out, kind[1] ? w : diff);
    chk("wr_en", file_wr_en_out, kind[1]);
    if (kind[1]) chk("wr_data", file_wr_data_out, diff);
    chk("carry", carry_out, w <= m);
    chk("half_carry", half_carry_out, w[3:0] <= m[3:0]);
    chk("zero", zero_out, diff == 8'h00);
    idle();
    $display("test_sub done");
  endtask
  // Sleep side effects, refusal while halted, frozen state, wake
  task automatic test_sleep();
    tick(384);
    chk("wdt", watchdog_counter_out, 8'h01);
    issue(rssalu_pkg::OP_SLEEP, 7'h00, 1'h0, 8'h00, 8'h00);
    chk("powerdown", powerdown_flag_out, 1'h0);
    chk("expiry", watchdog_expiry_flag_out, 1'h1);
    chk("wdt", watchdog_counter_out, 8'h00);
    chk("halted", halted_out, 1'h1);
    chk("osc_stop", osc_stop_out, 1'h1);
    issue(rssalu_pkg::OP_LIT_SUB, 7'h00, 1'h0, 8'h33, 8'h00);
    chk("acc_asleep", acc_out, 8'h00);
    chk("halted", halted_out, 1'h1);
    idle();
    wake_in = 1'h1;
    @(negedge sys_clk_in);
    wake_in = 1'h0;
    chk("halted", halted_out, 1'h0);
    chk("osc_stop", osc_stop_out, 1'h0);
    // Prescaler must restart from zero, else the count moves early
    tick(255);
    chk("wdt_pre", watchdog_counter_out, 8'h00);
    tick(1);
    chk("wdt_pre", watchdog_counter_out, 8'h01);
    ce_in = 1'h0;
    issue(rssalu_pkg::OP_LIT_SUB, 7'h00, 1'h0, 8'h44, 8'h00);
    chk("acc_frozen", acc_out, 8'h00);
    idle();
    ce_in = 1'h1;
    $display("test_sleep done");
  endtask
  // Reset in mid-run while asleep, then an instruction at first edge
  task automatic test_reset();
    issue(rssalu_pkg::OP_LIT_SUB, 7'h00, 1'h0, 8'h5A, 8'h00);
    chk("acc", acc_out, 8'h5A);
    issue(rssalu_pkg::OP_SLEEP, 7'h00, 1'h0, 8'h00, 8'h00);
    chk("powerdown", powerdown_flag_out, 1'h0);
    idle();
    rstn_in = 1'h0;
    repeat (10) @(negedge sys_clk_in);
    chk("rst_flags", {powerdown_flag_out, watchdog_expiry_flag_out}, 2'h3);
    chk("rst_acc", acc_out, 8'h00);
    chk("rst_halted", halted_out, 1'h0);
    rstn_in = 1'h1;
    issue(rssalu_pkg::OP_LIT_SUB, 7'h00, 1'h0, 8'h07, 8'h00);
    chk("acc", acc_out, 8'h07);
    chk("carry", carry_out, 1'h1);
    chk("half_carry", half_carry_out, 1'h1);
    idle();
    $display("test_reset done");
  endtask
  // ==========================================================
  // Verdict
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_fail++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    {rstn_in, op_valid_in, dest_in, wake_in, wdt_tick_in} = 5'h00;
    {op_code_in, file_addr_in, literal_in, file_rd_data_in} = 26'h0;
    ce_in = 1'h1;
    repeat (10) @(negedge sys_clk_in);
    chk("rst_flags", {powerdown_flag_out, watchdog_expiry_flag_out}, 2'h3);
    rstn_in = 1'h1;
    test_rotate();
    test_sub(2'h0, 8'h05, 8'h03);
    test_sub(2'h0, 8'h1F, 8'h20);
    test_sub(2'h0, 8'h80, 8'h80);
    test_sub(2'h1, 8'h03, 8'hF5);
    test_sub(2'h2, 8'hFF, 8'h00);
    test_sub(2'h0, 8'h00, 8'h00);
    test_sleep();
    test_reset();
    tally_and_finish();
  end
endmodule // rotate_subtract_sleep_alu_tb
